// >>> design/ifeb_bank_if.sv
// carrier between the register front end and the flag bank
`timescale 1ns/1ps
interface ifeb_bank_if #(parameter int N = 12);
  logic wr;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [N-1:0] set;
  logic [N-1:0] ack;
  logic [N-1:0] flag;
  logic [N-1:0] en;
  logic [N-1:0] ovr;
  modport bank (input wr, input addr, input wdata, input set, input ack, output flag, output en, output ovr);
  modport ctl (output wr, output addr, output wdata, output set, output ack, input flag, input en, input ovr);
endinterface

// >>> design/ifeb_evt_status.sv
// sticky event status, mask and interrupt line
`timescale 1ns/1ps
module ifeb_evt_status #(parameter int W = 4) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] evt,
  input wire logic wr_status,
  input wire logic wr_mask,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);
  logic [W-1:0] status_ff;
  logic [W-1:0] mask_ff;
  logic [W-1:0] nxt_status;
  // write one to clear; a fresh event in the same cycle stays set
  always_comb begin
    nxt_status = status_ff & ~(wr_status ? wdata : {W{1'b0}});
    nxt_status = nxt_status | evt;
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_ff <= W'(ifeb_pkg::RST_EVT);
    end else begin
      status_ff <= nxt_status;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_ff <= W'(ifeb_pkg::RST_EVT);
    end else if (wr_mask) begin
      mask_ff <= wdata;
    end
  end
  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = |(status_ff & mask_ff);
endmodule

// >>> design/ifeb_flag_bank.sv
// per-source request flags and enable bits
`timescale 1ns/1ps
module ifeb_flag_bank #(parameter int N = 12) (
  input wire logic clk,
  input wire logic reset_n,
  ifeb_bank_if.bank bif
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      logic flag_ff;
      logic en_ff;
      logic hit;
      assign hit = bif.wr && (bif.addr == ifeb_pkg::SRC_REG[i]);
      // set beats both software write and core ack, so no request is lost
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          flag_ff <= 1'b0; // RULE18
        end else if (bif.set[i]) begin
          flag_ff <= 1'b1; // RULE9
        end else if (bif.ack[i]) begin
          flag_ff <= 1'b0;
        end else if (hit) begin
          flag_ff <= bif.wdata[ifeb_pkg::FLAG_BIT[i]]; // RULE8
        end
      end
      // enables change only by software
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          en_ff <= 1'b0; // RULE18
        end else if (hit) begin
          en_ff <= bif.wdata[ifeb_pkg::EN_BIT[i]]; // RULE15
        end
      end
      assign bif.flag[i] = flag_ff;
      assign bif.en[i] = en_ff;
      assign bif.ovr[i] = bif.set[i] & flag_ff; // request lands on an already pending flag
    end
  endgenerate
endmodule

// >>> design/ifeb_pkg.sv
// constants of the interrupt flag and enable bank
package ifeb_pkg;
  localparam int NSRC = 12;
  localparam int NEVT = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_EVT = 4'h0;
  // register offsets
  localparam logic [2:0] A_FIRST = 3'h0;
  localparam logic [2:0] A_SECOND = 3'h1;
  localparam logic [2:0] A_THIRD = 3'h2;
  localparam logic [2:0] A_STATUS = 3'h3;
  localparam logic [2:0] A_MASK = 3'h4;
  // source indices
  localparam int SRC_CP0 = 0;
  localparam int SRC_CP1 = 1;
  localparam int SRC_MF0 = 2;
  localparam int SRC_MF1 = 3;
  localparam int SRC_MF2 = 4;
  localparam int SRC_MF3 = 5;
  localparam int SRC_MF4 = 6;
  localparam int SRC_SIM = 7;
  localparam int SRC_SPA = 8;
  localparam int SRC_TB0 = 9;
  localparam int SRC_TB1 = 10;
  localparam int SRC_MF5 = 11;
  // per source: home register, flag bit, enable bit
  localparam logic [2:0] SRC_REG [NSRC] = '{A_FIRST, A_FIRST, A_FIRST, A_FIRST, A_SECOND, A_SECOND,
    A_SECOND, A_SECOND, A_THIRD, A_THIRD, A_THIRD, A_THIRD};
  localparam int FLAG_BIT [NSRC] = '{4, 5, 6, 7, 4, 5, 6, 7, 4, 5, 6, 7};
  localparam int EN_BIT [NSRC] = '{0, 1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3};
  // event status bits
  localparam int EVT_OVR = 3;
endpackage

// >>> design/ifeb_top.sv
// interrupt flag and enable bank: register front end, gating and checks
// Overview of operation
// RULE1: serial module flag at bit 7, enable at bit 3 of second register.
// RULE2: group 4 request flag at bit 6 of second register.
// RULE3: group 3 request flag at bit 5 of second register.
// RULE4: group 2 request flag at bit 4 of second register.
// RULE5: group 4 enable at bit 2 of second register.
// RULE6: group 3 enable at bit 1 of second register.
// RULE7: group 2 enable at bit 0 of second register.
// RULE8: group 5 flag at bit 7 of third register, read and write.
// RULE9: time base 0 flag at bit 5 of third register, set on request.
// RULE10: time base 1 enable at bit 2 of third register.
// RULE11: time base 0 enable at bit 1 of third register.
// RULE12: comparator 1 flag reads 1 while its request is pending.
// RULE13: comparator 0 flag reads 1 while its request is pending.
// RULE14: group 0 and group 1 flags read 1 while pending.
// RULE15: separate enables for comparators 0, 1 and groups 0, 1.
// RULE16: request goes to the core only while flag and enable both 1.
// RULE17: third register: time base 1 flag 6, port a flag 4, group 5 enable 3, port a enable 0.
// RULE18: power-on reset clears every flag and enable.
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ifeb_top #(parameter int NSRC = 12) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [NSRC-1:0] src_set,
  input wire logic [NSRC-1:0] src_ack,
  output logic [NSRC-1:0] irq_req,
  output logic irq
);
  ifeb_bank_if #(.N(NSRC)) bif ();
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] evt;
  logic [3:0] status;
  logic [3:0] mask;
  logic wr_status;
  logic wr_mask;

  // drive the bank; sources and core ack come from same-clock logic
  assign bif.wr = wr;
  assign bif.addr = addr;
  assign bif.wdata = wdata;
  assign bif.set = src_set;
  assign bif.ack = src_ack;

  ifeb_flag_bank #(.N(NSRC)) u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .bif(bif)
  );

  // only pending and enabled sources reach the core
  assign irq_req = bif.flag & bif.en; // RULE16

  // events: a new request per register group, and any overrun
  always_comb begin
    evt = 4'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (src_set[i]) begin
        evt[ifeb_pkg::SRC_REG[i][1:0]] = 1'b1;
      end
    end
    evt[ifeb_pkg::EVT_OVR] = |bif.ovr;
  end

  assign wr_status = wr && (addr == ifeb_pkg::A_STATUS);
  assign wr_mask = wr && (addr == ifeb_pkg::A_MASK);

  ifeb_evt_status #(.W(ifeb_pkg::NEVT)) u_evt (
    .clk(clk),
    .reset_n(reset_n),
    .evt(evt),
    .wr_status(wr_status),
    .wr_mask(wr_mask),
    .wdata(wdata[3:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = ifeb_pkg::RST_BYTE;
    for (int i = 0; i < NSRC; i++) begin
      if (addr == ifeb_pkg::SRC_REG[i]) begin
        nxt_rdata[ifeb_pkg::FLAG_BIT[i]] = bif.flag[i]; // RULE12
        nxt_rdata[ifeb_pkg::EN_BIT[i]] = bif.en[i]; // RULE17
      end
    end
    if (addr == ifeb_pkg::A_STATUS) begin
      nxt_rdata = {4'h0, status};
    end else if (addr == ifeb_pkg::A_MASK) begin
      nxt_rdata = {4'h0, mask};
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_ff <= ifeb_pkg::RST_BYTE;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= ifeb_pkg::RST_BYTE;
    end
  end
  assign rdata = rdata_ff;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rd(logic [2:0] a);
    rd && (addr == a);
  endsequence

  sequence s_wr(logic [2:0] a);
    wr && (addr == a);
  endsequence

  // write that no request or ack of the same source overrides
  sequence s_wr_quiet(logic [2:0] a, int s);
    wr && (addr == a) && !src_set[s] && !src_ack[s];
  endsequence

  sequence s_tb0_pend;
    src_set[ifeb_pkg::SRC_TB0] ##1 s_rd(ifeb_pkg::A_THIRD);
  endsequence

  a_sim_bits: // RULE1
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[7] == $past(bif.flag[ifeb_pkg::SRC_SIM])
    && rdata[3] == $past(bif.en[ifeb_pkg::SRC_SIM]))
    else $error("serial module bits misplaced");

  a_mf4_flag: // RULE2
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[6] == $past(bif.flag[ifeb_pkg::SRC_MF4]))
    else $error("group 4 flag misplaced");

  a_mf3_flag: // RULE3
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[5] == $past(bif.flag[ifeb_pkg::SRC_MF3]))
    else $error("group 3 flag misplaced");

  a_mf2_flag: // RULE4
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[4] == $past(bif.flag[ifeb_pkg::SRC_MF2]))
    else $error("group 2 flag misplaced");

  a_mf4_enable: // RULE5
  assert property (s_wr(ifeb_pkg::A_SECOND) |=> bif.en[ifeb_pkg::SRC_MF4] == $past(wdata[2]))
    else $error("group 4 enable not written");

  a_mf3_enable: // RULE6
  assert property (s_wr(ifeb_pkg::A_SECOND) |=> bif.en[ifeb_pkg::SRC_MF3] == $past(wdata[1]))
    else $error("group 3 enable not written");

  a_mf2_enable: // RULE7
  assert property (s_wr(ifeb_pkg::A_SECOND) |=> bif.en[ifeb_pkg::SRC_MF2] == $past(wdata[0]))
    else $error("group 2 enable not written");

  a_mf5_write: // RULE8
  assert property (s_wr_quiet(ifeb_pkg::A_THIRD, ifeb_pkg::SRC_MF5)
    |=> bif.flag[ifeb_pkg::SRC_MF5] == $past(wdata[7]))
    else $error("group 5 flag not written");

  a_tb0_pending: // RULE9
  assert property (s_tb0_pend |=> rdata[5])
    else $error("time base 0 request not held");

  a_tb1_enable: // RULE10
  assert property (s_wr(ifeb_pkg::A_THIRD) |=> bif.en[ifeb_pkg::SRC_TB1] == $past(wdata[2]))
    else $error("time base 1 enable not written");

  a_tb0_enable: // RULE11
  assert property (s_wr(ifeb_pkg::A_THIRD) |=> bif.en[ifeb_pkg::SRC_TB0] == $past(wdata[1]))
    else $error("time base 0 enable not written");

  a_cp1_flag: // RULE12
  assert property (src_set[ifeb_pkg::SRC_CP1] ##1 s_rd(ifeb_pkg::A_FIRST) |=> rdata[5])
    else $error("comparator 1 request not seen");

  a_cp0_flag: // RULE13
  assert property (src_set[ifeb_pkg::SRC_CP0] ##1 s_rd(ifeb_pkg::A_FIRST) |=> rdata[4])
    else $error("comparator 0 request not seen");

  a_mf_low_flags: // RULE14
  assert property (s_rd(ifeb_pkg::A_FIRST) |=> rdata[7] == $past(bif.flag[ifeb_pkg::SRC_MF1])
    && rdata[6] == $past(bif.flag[ifeb_pkg::SRC_MF0]))
    else $error("group 0 or 1 flag misplaced");

  a_first_enables: // RULE15
  assert property (s_wr(ifeb_pkg::A_FIRST) |=> bif.en[3:0] == $past(wdata[3:0]))
    else $error("first register enables not written");

  a_gate_block: // RULE16
  assert property (s_wr(ifeb_pkg::A_SECOND) ##0 !wdata[3] |=> !irq_req[ifeb_pkg::SRC_SIM])
    else $error("disabled source reached the core");

  a_gate_pass: // RULE16
  assert property (src_set[ifeb_pkg::SRC_TB0] && bif.en[ifeb_pkg::SRC_TB0] && !wr
    |=> irq_req[ifeb_pkg::SRC_TB0])
    else $error("enabled request did not reach the core");

  a_third_layout: // RULE17
  assert property (s_rd(ifeb_pkg::A_THIRD) |=> rdata[6] == $past(bif.flag[ifeb_pkg::SRC_TB1])
    && rdata[4] == $past(bif.flag[ifeb_pkg::SRC_SPA]) && rdata[3] == $past(bif.en[ifeb_pkg::SRC_MF5])
    && rdata[0] == $past(bif.en[ifeb_pkg::SRC_SPA]))
    else $error("third register layout wrong");

  a_reset_clear: // RULE18
  assert property (@(posedge clk) disable iff (1'b0) !reset_n |=> bif.flag == '0 && bif.en == '0 && !irq)
    else $error("bank not cleared by reset");

  a_set_wins:
  assert property (src_set[ifeb_pkg::SRC_CP0] && src_ack[ifeb_pkg::SRC_CP0] |=> bif.flag[ifeb_pkg::SRC_CP0])
    else $error("clear beat a new request");

  a_rdata_once:
  assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  a_evt_sticky:
  assert property (status[0] && !wr_status |=> status[0])
    else $error("event status bit dropped");

  // software writes land on the second register flags and the enables not yet checked
  a_sim_enable: // RULE1
  assert property (s_wr(ifeb_pkg::A_SECOND) |=> bif.en[ifeb_pkg::SRC_SIM] == $past(wdata[3]))
    else $error("serial module enable not written");

  a_sim_write: // RULE1
  assert property (s_wr_quiet(ifeb_pkg::A_SECOND, ifeb_pkg::SRC_SIM)
    |=> bif.flag[ifeb_pkg::SRC_SIM] == $past(wdata[7]))
    else $error("serial module flag not written");

  a_mf4_write: // RULE2
  assert property (s_wr_quiet(ifeb_pkg::A_SECOND, ifeb_pkg::SRC_MF4)
    |=> bif.flag[ifeb_pkg::SRC_MF4] == $past(wdata[6]))
    else $error("group 4 flag not written");

  a_mf3_write: // RULE3
  assert property (s_wr_quiet(ifeb_pkg::A_SECOND, ifeb_pkg::SRC_MF3)
    |=> bif.flag[ifeb_pkg::SRC_MF3] == $past(wdata[5]))
    else $error("group 3 flag not written");

  a_mf2_write: // RULE4
  assert property (s_wr_quiet(ifeb_pkg::A_SECOND, ifeb_pkg::SRC_MF2)
    |=> bif.flag[ifeb_pkg::SRC_MF2] == $past(wdata[4]))
    else $error("group 2 flag not written");

  a_third_enables: // RULE17
  assert property (s_wr(ifeb_pkg::A_THIRD) |=> bif.en[ifeb_pkg::SRC_SPA] == $past(wdata[0])
    && bif.en[ifeb_pkg::SRC_MF5] == $past(wdata[3]))
    else $error("third register enables not written");

  // read side of the bits that the layout checks above leave out
  a_mf5_read: // RULE8
  assert property (s_rd(ifeb_pkg::A_THIRD) |=> rdata[7] == $past(bif.flag[ifeb_pkg::SRC_MF5]))
    else $error("group 5 flag misplaced");

  a_tb0_read: // RULE9
  assert property (s_rd(ifeb_pkg::A_THIRD) |=> rdata[5] == $past(bif.flag[ifeb_pkg::SRC_TB0]))
    else $error("time base 0 flag misplaced");

  a_tb1_en_read: // RULE10
  assert property (s_rd(ifeb_pkg::A_THIRD) |=> rdata[2] == $past(bif.en[ifeb_pkg::SRC_TB1]))
    else $error("time base 1 enable misplaced");

  a_tb0_en_read: // RULE11
  assert property (s_rd(ifeb_pkg::A_THIRD) |=> rdata[1] == $past(bif.en[ifeb_pkg::SRC_TB0]))
    else $error("time base 0 enable misplaced");

  a_mf4_en_read: // RULE5
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[2] == $past(bif.en[ifeb_pkg::SRC_MF4]))
    else $error("group 4 enable misplaced");

  a_mf3_en_read: // RULE6
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[1] == $past(bif.en[ifeb_pkg::SRC_MF3]))
    else $error("group 3 enable misplaced");

  a_mf2_en_read: // RULE7
  assert property (s_rd(ifeb_pkg::A_SECOND) |=> rdata[0] == $past(bif.en[ifeb_pkg::SRC_MF2]))
    else $error("group 2 enable misplaced");

  a_cp1_read: // RULE12
  assert property (s_rd(ifeb_pkg::A_FIRST) |=> rdata[5] == $past(bif.flag[ifeb_pkg::SRC_CP1]))
    else $error("comparator 1 flag misplaced");

  a_cp0_read: // RULE13
  assert property (s_rd(ifeb_pkg::A_FIRST) |=> rdata[4] == $past(bif.flag[ifeb_pkg::SRC_CP0]))
    else $error("comparator 0 flag misplaced");

  a_first_en_read: // RULE15
  assert property (s_rd(ifeb_pkg::A_FIRST) |=> rdata[3:0] == $past(bif.en[3:0]))
    else $error("first register enables misplaced");

  // a request followed at once by a read shows up
  a_mf1_request: // RULE14
  assert property (src_set[ifeb_pkg::SRC_MF1] ##1 s_rd(ifeb_pkg::A_FIRST) |=> rdata[7])
    else $error("group 1 request not seen");

  a_mf0_request: // RULE14
  assert property (src_set[ifeb_pkg::SRC_MF0] ##1 s_rd(ifeb_pkg::A_FIRST) |=> rdata[6])
    else $error("group 0 request not seen");

  // gating and the life of a flag
  a_gate_off: // RULE16
  assert property (s_wr(ifeb_pkg::A_THIRD) ##0 !wdata[1] |=> !irq_req[ifeb_pkg::SRC_TB0])
    else $error("disabled time base 0 reached the core");

  a_set_lands:
  assert property (src_set != '0 |=> (bif.flag & $past(src_set)) == $past(src_set))
    else $error("request did not set its flag");

  a_ack_clears:
  assert property ((src_ack & ~src_set) != '0 |=> (bif.flag & $past(src_ack & ~src_set)) == '0)
    else $error("acknowledged flag still pending");

  a_reset_outputs: // RULE18
  assert property (@(posedge clk) disable iff (1'b0) !reset_n |=> rdata == 8'h00 && irq_req == '0)
    else $error("outputs not cleared by reset");

  // unmapped offsets, event status and mask
  a_unmapped_read:
  assert property (rd && (addr > ifeb_pkg::A_MASK) |=> rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  a_unmapped_write:
  assert property (wr && (addr > ifeb_pkg::A_MASK) && src_set == '0 && src_ack == '0
    |=> $stable(bif.flag) && $stable(bif.en) && $stable(status) && $stable(mask))
    else $error("write to unmapped offset changed state");

  a_status_read:
  assert property (s_rd(ifeb_pkg::A_STATUS) |=> rdata == {4'h0, $past(status)})
    else $error("event status read wrong");

  a_mask_read:
  assert property (s_rd(ifeb_pkg::A_MASK) |=> rdata == {4'h0, $past(mask)})
    else $error("event mask read wrong");

  a_mask_write:
  assert property (s_wr(ifeb_pkg::A_MASK) |=> mask == $past(wdata[3:0]))
    else $error("event mask not written");

  a_evt_clear:
  assert property (s_wr(ifeb_pkg::A_STATUS) ##0 (src_set == '0) |=> (status & $past(wdata[3:0])) == 4'h0)
    else $error("event status not cleared");

  a_evt_group:
  assert property (src_set[ifeb_pkg::SRC_TB0] |=> status[2])
    else $error("third group event not recorded");

  a_evt_overrun:
  assert property (src_set[ifeb_pkg::SRC_CP0] && bif.flag[ifeb_pkg::SRC_CP0] |=> status[3])
    else $error("overrun not recorded");
endmodule

// >>> verification/ifeb_core_model.sv
// cpu core stand-in that takes pending requests and acknowledges them
`timescale 1ns/1ps
module ifeb_core_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] irq_req,
  input wire logic active,
  input wire logic slow,
  output logic [11:0] src_ack
);
  int cnt;
  // ack lowest pending source; slow mode stalls five cycles, one idle cycle after each ack
  always @(posedge clk) begin
    src_ack <= 12'h000;
    cnt <= 0;
    if (reset_n && active && irq_req != 12'h000 && src_ack == 12'h000) begin
      if (cnt < (slow ? 5 : 0)) begin
        cnt <= cnt + 1;
      end else begin
        src_ack <= irq_req & (~irq_req + 12'h001);
      end
    end
  end
endmodule

// >>> verification/tb_top.sv
// self-checking bench of the interrupt flag and enable bank
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] src_set = 12'h000;
  logic active = 1'b0;
  logic slow = 1'b0;
  logic chk_on = 1'b0;
  logic [7:0] rdata;
  logic [11:0] src_ack;
  logic [11:0] irq_req;
  logic irq;
  logic [11:0] m_flag;
  logic [11:0] m_en;
  logic [11:0] old_f;
  logic [3:0] m_st;
  logic [3:0] m_mk;
  logic [7:0] exp_rd;
  logic [31:0] r;
  logic [7:0] pat [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'h907DA5B4;

  ifeb_top u_ifeb_top (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .src_set(src_set), .src_ack(src_ack), .irq_req(irq_req), .irq(irq));
  ifeb_core_model u_ifeb_core_model (.clk(clk), .reset_n(reset_n), .irq_req(irq_req), .active(active),
    .slow(slow), .src_ack(src_ack));

  initial forever #5 clk = ~clk;

  // register image: source i lives in register i/4, flag at bit 4+i%4, enable at bit i%4
  function automatic logic [7:0] reg_val(int a);
    logic [7:0] v;
    v = 8'h00;
    if (a < 3) begin
      for (int k = 0; k < 4; k++) begin
        v[4 + k] = m_flag[a * 4 + k];
        v[k] = m_en[a * 4 + k];
      end
    end else if (a == 3) begin
      v = {4'h0, m_st};
    end else if (a == 4) begin
      v = {4'h0, m_mk};
    end
    return v;
  endfunction

  // reference model: software write, then ack, then set, each one winning over the one before
  always @(posedge clk) begin
    exp_rd = rd ? reg_val(addr) : 8'h00;
    old_f = m_flag;
    if (!reset_n) begin
      m_flag = 12'h000;
      m_en = 12'h000;
      m_st = 4'h0;
      m_mk = 4'h0;
      exp_rd = 8'h00;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (wr && addr < 3'h3) begin
          m_flag[addr * 4 + k] = wdata[4 + k];
          m_en[addr * 4 + k] = wdata[k];
        end
      end
      if (wr && addr == 3'h3) m_st = m_st & ~wdata[3:0];
      if (wr && addr == 3'h4) m_mk = wdata[3:0];
      m_flag = (m_flag & ~src_ack) | src_set;
      for (int i = 0; i < 12; i++) begin
        if (src_set[i]) begin
          m_st[i / 4] = 1'b1;
          if (old_f[i]) m_st[3] = 1'b1; // a repeated request counts as overrun
        end
      end
    end
  end

  task automatic check(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare at the falling edge so every update of the rising edge has landed
  always @(negedge clk) begin
    if (chk_on) begin
      check("irq_req", m_flag & m_en, irq_req);
      check("irq", {11'h000, |(m_st & m_mk)}, {11'h000, irq});
      check("rdata", {4'h0, exp_rd}, {4'h0, rdata});
    end
  end

  task automatic bus(logic w, logic rr, logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= rr;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog, about sixteen times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    @(posedge clk);
    chk_on <= 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, 3'(a), 8'h00);
    $display("test reset_values done");
    foreach (pat[j]) begin
      for (int a = 0; a < 8; a++) begin
        bus(1'b1, 1'b0, 3'(a), pat[j]);
        bus(1'b0, 1'b1, 3'(a), 8'h00);
      end
    end
    $display("test register_access done");
    for (int a = 0; a < 5; a++) bus(1'b1, 1'b0, 3'(a), 8'h0F);
    active <= 1'b1;
    // odd sources repeat the request while the slow core stalls, giving an overrun
    for (int i = 0; i < 12; i++) begin
      slow <= i[0];
      @(posedge clk);
      src_set <= 12'h001 << i;
      @(posedge clk);
      src_set <= (12'h001 << i) & {12{i[0]}};
      @(posedge clk);
      src_set <= 12'h000;
      bus(1'b0, 1'b1, 3'(i / 4), 8'h00);
      bus(1'b0, 1'b1, 3'h3, 8'h00);
      repeat (8) @(posedge clk);
      bus(1'b1, 1'b0, 3'h3, 8'h0F);
    end
    $display("test per_source done");
    // random traffic with a second reset in mid-run
    for (int c = 0; c < 800; c++) begin
      @(posedge clk);
      r = $random(seed);
      src_set <= r[11:0] & r[23:12] & {12{r[24]}};
      wr <= r[25] & ~r[26];
      rd <= r[26];
      addr <= r[29:27];
      wdata <= r[7:0] ^ r[31:24];
      slow <= r[30];
      if (c == 400) reset_n <= 1'b0;
      if (c == 402) reset_n <= 1'b1;
    end
    @(posedge clk);
    src_set <= 12'h000;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (20) @(posedge clk);
    for (int a = 0; a < 8; a++) bus(1'b0, 1'b1, 3'(a), 8'h00);
    $display("test random_traffic done");
    give_verdict();
  end
endmodule
